// ===== output_routing_consts.svh
`ifndef OUTPUT_ROUTING_CONSTS_SVH
`define OUTPUT_ROUTING_CONSTS_SVH

// ****************************************************
// register indices; byte address is four times these
// ****************************************************
`define FREEWHEEL_EXTERNAL_REQUEST_IDX        12'h016a
`define DIAG_SEL_IDX          12'h016b
`define DEAD_TIME_IDX         12'h016c
`define ROUTE_STATUS_IDX      12'h016d

// ****************************************************
// reset values and fields
// ****************************************************
`define FREEWHEEL_EXTERNAL_REQUEST_RST        5'h00
`define DIAG_SEL_RST          1'h1
`define DEAD_TIME_RST         8'h10
`define FREEWHEEL_EXTERNAL_REQUEST_W          5
`define DEAD_TIME_W           8
`define STATUS_OUT_EN_BIT     5

// ****************************************************
// output numbering: 0..4 high side 1..5, 5..11 low side 1..7
// ****************************************************
`define NUM_OUTPUTS           12
`define NUM_FW_PAIRS          5
`define HIGH_SIDE_5_IDX       4
`define LOW_SIDE_4_IDX        8
`define LOW_SIDE_5_IDX        9
`define LOW_SIDE_6_IDX        10
`define LOW_SIDE_7_IDX        11

`endif

// ===== output_routing_pkg.sv
package output_routing_pkg;
    typedef logic [11:0] cmd_vec_t;
    typedef logic [4:0]  fw_vec_t;
    typedef logic [7:0]  dead_time_t;
endpackage

// ===== freewheel_link_if.sv
`timescale 1ns/1ps
interface freewheel_link_if;
    import output_routing_pkg::*;
    logic       hs_req;
    logic       auto_en;
    dead_time_t delay;
    logic       hs_cmd;
    logic       fw_cmd;
    modport ctrl (output hs_req, output auto_en, output delay, input hs_cmd, input fw_cmd);
    modport chan (input hs_req, input auto_en, input delay, output hs_cmd, output fw_cmd);
endinterface

// ===== freewheel_channel.sv
`timescale 1ns/1ps
module freewheel_channel (
    input  wire logic     clk_in,
    input  wire logic     arst_n_in,
    freewheel_link_if.chan link
);
    import output_routing_pkg::*;

    dead_time_t cnt_reg,    cnt_next;
    logic       last_reg,   last_next;
    logic       hs_reg,     hs_next;
    logic       fw_reg,     fw_next;

    // ****************************************************
    // dead time sequencing
    // ****************************************************
    always_comb begin
        cnt_next  = cnt_reg;
        last_next = link.hs_req;
        hs_next   = hs_reg;
        fw_next   = fw_reg;
        if (!link.auto_en) begin
            cnt_next = '0;
            hs_next  = link.hs_req;
            fw_next  = 1'b0;
        end else if (link.hs_req != last_reg) begin
            // any edge parks both sides low before the new state
            cnt_next = '0;
            hs_next  = 1'b0;
            fw_next  = 1'b0;
        end else if (cnt_reg < link.delay) begin
            cnt_next = cnt_reg + 8'h01;
        end else begin
            hs_next = link.hs_req;
            fw_next = ~link.hs_req;
        end
    end

    always_ff @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            cnt_reg  <= '0;
            last_reg <= 1'b0;
            hs_reg   <= 1'b0;
            fw_reg   <= 1'b0;
        end else begin
            cnt_reg  <= cnt_next;
            last_reg <= last_next;
            hs_reg   <= hs_next;
            fw_reg   <= fw_next;
        end
    end

    assign link.hs_cmd = hs_reg;
    assign link.fw_cmd = fw_reg;
endmodule // freewheel_channel

// ===== output_routing_freewheel_ctrl.sv
// Chosen here: the APB interface to the registers.
`timescale 1ns/1ps
`include "output_routing_consts.svh"
// How it works
// - pick sequencer, input flag, or freewheel source
// - automatic freewheel only on five outputs
// - fixed pairing of freewheel and high side
// - auto freewheel is inverse of high side
// - auto mode ignores sequencer freewheel requests
// - freewheel rises dead time after high falls
// - high side rise delayed by dead time
// - manual mode: sequencer request or selected input flag drives the output
// - register bit enables freewheel without microcode
// - per-output enable bits select freewheel pairing
// - option 0: diagnosis sees sequencer forced command
// - option 1: diagnosis off for disabled outputs
module output_routing_freewheel_ctrl (
    input  wire logic                          clk_in,
    input  wire logic                          arst_n_in,
    input  wire logic                          psel_in,
    input  wire logic                          penable_in,
    input  wire logic                          pwrite_in,
    input  wire logic [15:0]                   paddr_in,
    input  wire logic [31:0]                   pwdata_in,
    output logic      [31:0]                   prdata_out,
    output logic                               pready_out,
    output logic                               pslverr_out,
    input  wire output_routing_pkg::cmd_vec_t  seq_request_in,
    input  wire output_routing_pkg::cmd_vec_t  sequencer_output_access_in,
    input  wire output_routing_pkg::cmd_vec_t  input_flag_in,
    input  wire output_routing_pkg::cmd_vec_t  flag_source_sel_in,
    input  wire output_routing_pkg::fw_vec_t   auto_freewheel_sel_in,
    input  wire logic                          driver_enable_pin_in,
    input  wire logic                          supply_undervoltage_in,
    output output_routing_pkg::cmd_vec_t       predriver_cmd_out,
    output output_routing_pkg::cmd_vec_t       diag_cmd_out
);
    import output_routing_pkg::*;

    // ****************************************************
    // registers and apb slave
    // ****************************************************
    fw_vec_t     fw_ext_reg,    fw_ext_next;
    logic        diag_sel_reg,  diag_sel_next;
    dead_time_t  dead_reg,      dead_next;
    logic [31:0] prdata_reg,    prdata_next;
    logic        pready_reg,    pready_next;
    logic        pslverr_reg,   pslverr_next;
    logic [13:0] word_idx;
    logic        hit;
    logic        wr_en;
    fw_vec_t     auto_eff;
    logic        out_en_reg;

    assign word_idx = paddr_in[15:2];
    assign wr_en    = psel_in & penable_in & pready_reg & pwrite_in;

    always_comb begin
        hit = 1'b1;
        prdata_next = 32'h0000_0000;
        case (word_idx)
            {2'b00, `FREEWHEEL_EXTERNAL_REQUEST_IDX}:   prdata_next[4:0] = fw_ext_reg;
            {2'b00, `DIAG_SEL_IDX}:     prdata_next[0]   = diag_sel_reg;
            {2'b00, `DEAD_TIME_IDX}:    prdata_next[7:0] = dead_reg;
            {2'b00, `ROUTE_STATUS_IDX}: prdata_next[5:0] = {out_en_reg, auto_eff};
            default:                    hit = 1'b0;
        endcase
        // answer is prepared in setup, held through the single access cycle
        pready_next   = psel_in & ~penable_in;
        pslverr_next  = psel_in & ~penable_in & ~hit;
        if (!(psel_in & ~penable_in)) begin
            prdata_next = prdata_reg;
        end
        fw_ext_next   = fw_ext_reg;
        diag_sel_next = diag_sel_reg;
        dead_next     = dead_reg;
        if (wr_en && !pslverr_reg) begin
            case (word_idx)
                {2'b00, `FREEWHEEL_EXTERNAL_REQUEST_IDX}: fw_ext_next   = pwdata_in[4:0];
                {2'b00, `DIAG_SEL_IDX}:   diag_sel_next = pwdata_in[0];
                {2'b00, `DEAD_TIME_IDX}:  dead_next     = pwdata_in[7:0];
                default: begin
                end
            endcase
        end
    end

    always_ff @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            fw_ext_reg   <= `FREEWHEEL_EXTERNAL_REQUEST_RST;
            diag_sel_reg <= `DIAG_SEL_RST;
            dead_reg     <= `DEAD_TIME_RST;
            prdata_reg   <= 32'h0000_0000;
            pready_reg   <= 1'b0;
            pslverr_reg  <= 1'b0;
        end else begin
            fw_ext_reg   <= fw_ext_next;
            diag_sel_reg <= diag_sel_next;
            dead_reg     <= dead_next;
            prdata_reg   <= prdata_next;
            pready_reg   <= pready_next;
            pslverr_reg  <= pslverr_next;
        end
    end

    // ****************************************************
    // driver enable pin synchroniser
    // ****************************************************
    logic [2:0] drv_sync_reg, drv_sync_next;
    logic       drv_en_reg,   drv_en_next;
    logic       out_en_next;

    always_comb begin
        drv_sync_next = {drv_sync_reg[1:0], driver_enable_pin_in};
        drv_en_next   = drv_en_reg;
        // a change counts only once the second and third stage agree
        if (drv_sync_reg[1] == drv_sync_reg[2]) begin
            drv_en_next = drv_sync_reg[2];
        end
        out_en_next = drv_en_reg & ~supply_undervoltage_in;
    end

    always_ff @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            drv_sync_reg <= 3'h0;
            drv_en_reg   <= 1'b0;
            out_en_reg   <= 1'b0;
        end else begin
            drv_sync_reg <= drv_sync_next;
            drv_en_reg   <= drv_en_next;
            out_en_reg   <= out_en_next;
        end
    end

    // ****************************************************
    // freewheel pairs
    // ****************************************************
    function automatic int fw_index(input int k);
        case (k)
            0:       fw_index = `LOW_SIDE_5_IDX;
            1:       fw_index = `LOW_SIDE_6_IDX;
            2:       fw_index = `LOW_SIDE_7_IDX;
            3:       fw_index = `HIGH_SIDE_5_IDX;
            default: fw_index = `LOW_SIDE_4_IDX;
        endcase
    endfunction

    cmd_vec_t base_cmd;
    fw_vec_t  hs_cmd;
    fw_vec_t  fw_cmd;

    assign auto_eff = auto_freewheel_sel_in | fw_ext_reg;
    // per output: merged sequencer request or a device input flag
    assign base_cmd = (flag_source_sel_in & input_flag_in)
                    | (~flag_source_sel_in & seq_request_in);

    freewheel_link_if link_if [`NUM_FW_PAIRS] ();

    genvar k;
    generate
        for (k = 0; k < `NUM_FW_PAIRS; k = k + 1) begin : g_pair
            // high side 5 may itself be a freewheel of high side 4
            if (k == `HIGH_SIDE_5_IDX) begin : g_chain
                assign link_if[k].hs_req = auto_eff[k-1] ? fw_cmd[k-1] : base_cmd[k];
            end else begin : g_plain
                assign link_if[k].hs_req = base_cmd[k];
            end
            assign link_if[k].auto_en = auto_eff[k];
            assign link_if[k].delay   = dead_reg;
            assign hs_cmd[k]          = link_if[k].hs_cmd;
            assign fw_cmd[k]          = link_if[k].fw_cmd;
            freewheel_channel u_chan (
                .clk_in    (clk_in),
                .arst_n_in (arst_n_in),
                .link      (link_if[k])
            );
        end
    endgenerate

    // ****************************************************
    // final routing and diagnosis command
    // ****************************************************
    cmd_vec_t route_cmd;
    cmd_vec_t cmd_reg,  cmd_next;
    cmd_vec_t diag_reg, diag_next;

    always_comb begin
        route_cmd = base_cmd;
        for (int p = 0; p < `NUM_FW_PAIRS; p++) begin
            if (auto_eff[p]) begin
                route_cmd[p] = hs_cmd[p];
            end
        end
        // freewheel overrides last: sequencer request to it is dropped
        for (int p = 0; p < `NUM_FW_PAIRS; p++) begin
            if (auto_eff[p]) begin
                route_cmd[fw_index(p)] = fw_cmd[p];
            end
        end
        cmd_next = out_en_reg ? route_cmd : '0;
        if (diag_sel_reg) begin
            diag_next = out_en_reg ? route_cmd : '0;
        end else begin
            diag_next = seq_request_in & sequencer_output_access_in;
        end
    end

    always_ff @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            cmd_reg  <= '0;
            diag_reg <= '0;
        end else begin
            cmd_reg  <= cmd_next;
            diag_reg <= diag_next;
        end
    end

    assign predriver_cmd_out = cmd_reg;
    assign diag_cmd_out      = diag_reg;
    assign prdata_out        = prdata_reg;
    assign pready_out        = pready_reg;
    assign pslverr_out       = pslverr_reg;
endmodule // output_routing_freewheel_ctrl

// ===== sequencer_model.sv
`timescale 1ns/1ps
// ****************************************************
// sequencer side: merged requests, access, auto select
// ****************************************************
module sequencer_model
    import output_routing_pkg::*;
(
    output cmd_vec_t req_out,
    output cmd_vec_t acc_out,
    output fw_vec_t  auto_out
);
    import output_routing_pkg::*;
    initial begin
        req_out  = 12'h000;
        acc_out  = 12'h000;
        auto_out = 5'h00;
    end
    // caller sits just after a rising edge, so the change lands by nba there
    task automatic put(input cmd_vec_t r, input cmd_vec_t a, input fw_vec_t f);
        req_out  <= r;
        acc_out  <= a;
        auto_out <= f;
    endtask
endmodule // sequencer_model

// ===== output_routing_freewheel_ctrl_sva.sv
`timescale 1ns/1ps
// ****************************************************
// port checker
// ****************************************************
module output_routing_freewheel_ctrl_sva
    import output_routing_pkg::*;
(
    input wire logic        clk_in,
    input wire logic        arst_n_in,
    input wire logic        psel_in,
    input wire logic        penable_in,
    input wire logic [15:0] paddr_in,
    input wire logic        pready_out,
    input wire logic        pslverr_out,
    input wire cmd_vec_t    seq_request_in,
    input wire cmd_vec_t    input_flag_in,
    input wire cmd_vec_t    flag_source_sel_in,
    input wire fw_vec_t     auto_freewheel_sel_in,
    input wire logic        supply_undervoltage_in,
    input wire cmd_vec_t    predriver_cmd_out,
    input wire cmd_vec_t    diag_cmd_out
);
    import output_routing_pkg::*;
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!arst_n_in);
    logic mapped;
    logic setup;
    assign mapped = paddr_in[15:2] >= 14'h016a && paddr_in[15:2] <= 14'h016d;
    assign setup  = psel_in && !penable_in;
    a_ready_next: assert property (setup |=> pready_out)
        else $error("no ready after setup");
    a_ready_pulse: assert property (pready_out |=> !pready_out)
        else $error("ready held too long");
    a_err_unmapped: assert property (setup && !mapped |=> pslverr_out)
        else $error("unmapped access not refused");
    a_err_mapped: assert property (setup && mapped |=> !pslverr_out)
        else $error("mapped access refused");
    // auto must have settled for a few cycles; the switch-over itself is left open
    a_gap_pair1: assert property (
        auto_freewheel_sel_in[0] && $past(auto_freewheel_sel_in[0], 3)
        |-> !(predriver_cmd_out[0] && predriver_cmd_out[9]))
        else $error("high side and freewheel overlap on pair 1");
    a_gap_pair3: assert property (
        auto_freewheel_sel_in[2] && $past(auto_freewheel_sel_in[2], 3)
        |-> !(predriver_cmd_out[2] && predriver_cmd_out[11]))
        else $error("high side and freewheel overlap on pair 3");
    a_manual_base: assert property (predriver_cmd_out[5] |->
        $past(flag_source_sel_in[5] ? input_flag_in[5] : seq_request_in[5]))
        else $error("low side 1 high without a source");
    a_uv_quiet: assert property (supply_undervoltage_in [*3]
        |-> predriver_cmd_out == 12'h000) else $error("output active while supply low");
    c_refused: cover property (setup && !mapped ##1 pslverr_out);
    c_hs_rise: cover property ($rose(predriver_cmd_out[0]));
    c_diag: cover property ($rose(diag_cmd_out[3]));
endmodule // output_routing_freewheel_ctrl_sva

bind output_routing_freewheel_ctrl output_routing_freewheel_ctrl_sva i_sva (
    .clk_in(clk_in), .arst_n_in(arst_n_in), .psel_in(psel_in), .penable_in(penable_in),
    .paddr_in(paddr_in), .pready_out(pready_out), .pslverr_out(pslverr_out),
    .seq_request_in(seq_request_in), .input_flag_in(input_flag_in),
    .flag_source_sel_in(flag_source_sel_in), .auto_freewheel_sel_in(auto_freewheel_sel_in),
    .supply_undervoltage_in(supply_undervoltage_in), .predriver_cmd_out(predriver_cmd_out),
    .diag_cmd_out(diag_cmd_out));

// ===== output_routing_freewheel_ctrl_tb.sv
`timescale 1ns/1ps
`define CHK(a, e) begin check_count++; if ((a) !== (e)) begin fails++; \
    $display("BAD t=%0t got %h exp %h", $time, (a), (e)); end end
module output_routing_freewheel_ctrl_tb;
    import output_routing_pkg::*;
    logic        clk_in = 0, arst_n_in = 0, psel = 0, penable = 0, pwrite = 0;
    logic        drv_en = 0, uv = 0, pready, pslverr, err;
    logic [15:0] paddr = 16'h0000;
    logic [31:0] pwdata = 32'h0000_0000, prdata, rd;
    cmd_vec_t    req, acc, pred, diag, flag = 12'h000, fsel = 12'h000;
    fw_vec_t     asel;
    int          fails = 0, check_count = 0, n;
    always #10 clk_in = ~clk_in;
    sequencer_model i_seq (.req_out(req), .acc_out(acc), .auto_out(asel));
    output_routing_freewheel_ctrl i_dut (.clk_in(clk_in), .arst_n_in(arst_n_in),
        .psel_in(psel), .penable_in(penable), .pwrite_in(pwrite), .paddr_in(paddr),
        .pwdata_in(pwdata), .prdata_out(prdata), .pready_out(pready), .pslverr_out(pslverr),
        .seq_request_in(req), .sequencer_output_access_in(acc), .input_flag_in(flag),
        .flag_source_sel_in(fsel), .auto_freewheel_sel_in(asel), .driver_enable_pin_in(drv_en),
        .supply_undervoltage_in(uv), .predriver_cmd_out(pred), .diag_cmd_out(diag));
    // ****************************************************
    // bus and timing helpers
    // ****************************************************
    task automatic give_verdict();
        $display("comparisons %0d mismatches %0d", check_count, fails);
        if (fails == 0 && check_count > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    // one leading edge keeps psel from being assigned twice in one step
    task automatic apb(input logic wr, input logic [15:0] a, input logic [31:0] wd);
        int k;
        @(posedge clk_in);
        psel <= 1; penable <= 0; pwrite <= wr; paddr <= a; pwdata <= wd;
        @(posedge clk_in);
        penable <= 1;
        k = 0;
        do begin @(posedge clk_in); k++; end while (pready !== 1'b1 && k < 20);
        if (k >= 20) begin fails++; give_verdict(); end
        rd = prdata;
        err = pslverr;
        psel <= 0; penable <= 0;
    endtask
    task automatic cyc(input int c);
        repeat (c) @(posedge clk_in);
    endtask
    // edges until an output bit shows a level; the first edge still sees the old value
    task automatic edges_to(input int idx, input logic v);
        n = 0;
        do begin @(posedge clk_in); n++; end while (pred[idx] !== v && n < 60);
        if (n >= 60) begin fails++; give_verdict(); end
    endtask
    // ****************************************************
    // main sequence
    // ****************************************************
    initial begin
        cyc(3);
        arst_n_in <= 1; drv_en <= 1;
        cyc(8);
        apb(1'b0, 16'h05a8, 32'h0000_0000); `CHK(rd, 32'h0000_0000)
        apb(1'b0, 16'h05ac, 32'h0000_0000); `CHK(rd, 32'h0000_0001)
        apb(1'b0, 16'h05b0, 32'h0000_0000); `CHK(rd, 32'h0000_0010)
        apb(1'b0, 16'h05c0, 32'h0000_0000); `CHK({err, rd}, {1'b1, 32'h0000_0000})
        apb(1'b1, 16'h05b0, 32'h0000_0002);
        i_seq.put(12'h200, 12'hfff, 5'h00); fsel <= 12'h020; flag <= 12'h020;
        cyc(4); `CHK(pred, 12'h220)
        i_seq.put(12'h200, 12'hfff, 5'h01); fsel <= 12'h000; flag <= 12'h000;
        cyc(8); `CHK(pred, 12'h200)
        i_seq.put(12'h201, 12'hfff, 5'h01);
        edges_to(0, 1); `CHK(n, 6)
        `CHK(pred[9], 1'b0)
        i_seq.put(12'h200, 12'hfff, 5'h01);
        edges_to(9, 1); `CHK(n, 6)
        i_seq.put(12'h000, 12'hfff, 5'h00);
        apb(1'b1, 16'h05a8, 32'h0000_0002);
        cyc(8); `CHK(pred, 12'h400)
        apb(1'b0, 16'h05b4, 32'h0000_0000); `CHK(rd, 32'h0000_0022)
        apb(1'b1, 16'h05a8, 32'h0000_001f);
        cyc(8); `CHK(pred, 12'he10)
        // high side 5 request must be dropped while it serves as freewheel
        i_seq.put(12'h01c, 12'h00c, 5'h04);
        cyc(12); `CHK(pred, 12'h70c)
        uv <= 1;
        cyc(6); `CHK(pred, 12'h000)
        `CHK(diag, 12'h000)
        apb(1'b1, 16'h05ac, 32'h0000_0000);
        cyc(3); `CHK(diag, 12'h00c)
        give_verdict();
    end
endmodule // output_routing_freewheel_ctrl_tb
